// ===== design/lsia_map.svh
// Constants for the load/store and immediate ALU datapath
// Summary of operation
// - Address is base register plus sign-extended 16-bit offset.
// - Signed byte load sign-extends the addressed byte to register width.
// - Word-left load shifts word left, merges bytes into target.
// - Doubleword-left load shifts left, merges into target, writes back.
// - Doubleword-right load shifts right, merges into target, writes back.
// - Doubleword-left store shifts register right, writes lower memory part.
// - Doubleword-right store shifts register left, writes upper memory part.
// - Byte store writes only the low byte of the target register.
// - Halfword store writes only the low halfword of the target.
// - Doubleword store writes the whole target register.
// - Add comes in register form and 16-bit immediate form; the other operations in immediate form only.
// - Trapping add-immediate gives 32-bit sign-extended sum, traps overflow.
// - Trapping doubleword add-immediate gives 64-bit sum, traps overflow.
// - Wrapping doubleword add-immediate gives same sum, never traps.
// - Signed compare with sign-extended immediate writes 1 or 0.
// - Unsigned compare still sign-extends immediate, compares unsigned.
// - AND, OR, XOR immediate zero-extend the immediate.
// - Load-upper puts immediate in bits 31:16, sign-extends the word in 64-bit mode, zero-extends it otherwise.
// - Illegal size and low address bits combination raises address error.
// - Address names the low-order byte of the field, little-endian.
`ifndef LSIA_MAP_SVH
`define LSIA_MAP_SVH
`define LSIA_IMM_W     16
`define LSIA_SHAMT_W   6
`define LSIA_RESET_DATA 64'h0000_0000_0000_0000
`define LSIA_RESET_STRB 8'h00
`endif

// ===== design/lsia_pkg.sv
// Types for the load/store and immediate ALU datapath
package lsia_pkg;
	typedef enum logic [4:0] {
		LSIA_NONE,
		LSIA_LOAD_BYTE_SIGNED, LSIA_LOAD_BYTE_ZERO_EXT,
		LSIA_LOAD_HALFWORD_SIGNED, LSIA_LOAD_HALFWORD_ZERO_EXT,
		LSIA_LOAD_WORD_SIGNED, LSIA_LOAD_WORD_ZERO_EXT,
		LSIA_LOAD_WORD_LEFT, LSIA_LOAD_WORD_RIGHT,
		LSIA_LOAD_DOUBLEWORD, LSIA_LOAD_DOUBLEWORD_LEFT,
		LSIA_LOAD_DOUBLEWORD_RIGHT,
		LSIA_STORE_BYTE, LSIA_STORE_HALFWORD, LSIA_STORE_WORD,
		LSIA_STORE_WORD_LEFT, LSIA_STORE_WORD_RIGHT,
		LSIA_STORE_DOUBLEWORD, LSIA_STORE_DOUBLEWORD_LEFT,
		LSIA_STORE_DOUBLEWORD_RIGHT,
		LSIA_ADD_IMMEDIATE_TRAPPING, LSIA_DWORD_ADD_IMMEDIATE_TRAPPING,
		LSIA_DWORD_ADD_IMMEDIATE_WRAPPING, LSIA_SET_LESS_THAN_IMM_SIGNED,
		LSIA_SET_LESS_THAN_IMM_UNSIGNED, LSIA_AND_IMMEDIATE,
		LSIA_OR_IMMEDIATE, LSIA_EXCLUSIVE_OR_IMMEDIATE,
		LSIA_LOAD_UPPER_IMMEDIATE, LSIA_ADD_REGISTER
	} lsia_op_e;
	typedef enum logic [2:0] {
		LSIA_ST_IDLE = 3'b001,
		LSIA_ST_MEM  = 3'b010,
		LSIA_ST_DONE = 3'b100
	} lsia_state_e;
endpackage : lsia_pkg

// ===== design/lsia_align.sv
// Byte lane alignment and merge for loads and stores
`timescale 1ns/1ps
`include "lsia_map.svh"
module lsia_align (
	input  wire lsia_pkg::lsia_op_e op_in,
	input  wire logic [2:0]         addr_lo_in,
	input  wire logic [63:0]        mem_rdata_in,
	input  wire logic [63:0]        target_in,
	output logic [63:0]             load_data_out,
	output logic [63:0]             store_data_out,
	output logic [7:0]              store_strb_out,
	output logic                    misaligned_out
);
	logic [5:0]  sh;
	logic [5:0]  shw;
	logic [63:0] wl;
	logic [63:0] wr;
	logic [31:0] wsel;
	logic [7:0]  wb;
	logic [15:0] wh;
	assign sh   = {addr_lo_in, 3'b000};
	assign shw  = {1'b0, addr_lo_in[1:0], 3'b000};
	assign wsel = addr_lo_in[2] ? mem_rdata_in[63:32] : mem_rdata_in[31:0];
	assign wb   = mem_rdata_in[sh +: 8];
	assign wh   = mem_rdata_in[sh +: 16];

	// Load extension and merge
	always_comb begin
		load_data_out = target_in;
		wl = 64'h0;
		wr = 64'h0;
		case (op_in)
			lsia_pkg::LSIA_LOAD_BYTE_SIGNED:
				load_data_out = {{56{wb[7]}}, wb};
			lsia_pkg::LSIA_LOAD_BYTE_ZERO_EXT: load_data_out = {56'h0, wb};
			lsia_pkg::LSIA_LOAD_HALFWORD_SIGNED:
				load_data_out = {{48{wh[15]}}, wh};
			lsia_pkg::LSIA_LOAD_HALFWORD_ZERO_EXT:
				load_data_out = {48'h0, wh};
			lsia_pkg::LSIA_LOAD_WORD_SIGNED:
				load_data_out = {{32{wsel[31]}}, wsel};
			lsia_pkg::LSIA_LOAD_WORD_ZERO_EXT:
				load_data_out = {32'h0, wsel};
			lsia_pkg::LSIA_LOAD_DOUBLEWORD: load_data_out = mem_rdata_in;
			lsia_pkg::LSIA_LOAD_WORD_LEFT: begin
				wl = {32'h0, wsel} << (6'd24 - shw);
				load_data_out[31:0] = (target_in[31:0]
					& ~(32'hffff_ffff << (6'd24 - shw)))
					| wl[31:0];
				load_data_out = {{32{load_data_out[31]}},
					load_data_out[31:0]};
			end
			lsia_pkg::LSIA_LOAD_WORD_RIGHT: begin
				wr = {32'h0, wsel} >> shw;
				load_data_out[31:0] = (target_in[31:0]
					& ~(32'hffff_ffff >> shw)) | wr[31:0];
				load_data_out = {{32{load_data_out[31]}},
					load_data_out[31:0]};
			end
			lsia_pkg::LSIA_LOAD_DOUBLEWORD_LEFT:
				load_data_out = (target_in
					& ~(64'hffff_ffff_ffff_ffff << (6'd56 - sh)))
					| (mem_rdata_in << (6'd56 - sh));
			lsia_pkg::LSIA_LOAD_DOUBLEWORD_RIGHT:
				load_data_out = (target_in
					& ~(64'hffff_ffff_ffff_ffff >> sh))
					| (mem_rdata_in >> sh);
			default: load_data_out = target_in;
		endcase
	end

	// Store lanes and strobes
	always_comb begin
		store_data_out = 64'h0;
		store_strb_out = `LSIA_RESET_STRB;
		case (op_in)
			lsia_pkg::LSIA_STORE_BYTE: begin
				store_data_out = {56'h0, target_in[7:0]} << sh;
				store_strb_out = 8'h01 << addr_lo_in;
			end
			lsia_pkg::LSIA_STORE_HALFWORD: begin
				store_data_out = {48'h0, target_in[15:0]} << sh;
				store_strb_out = 8'h03 << addr_lo_in;
			end
			lsia_pkg::LSIA_STORE_WORD: begin
				store_data_out = {32'h0, target_in[31:0]} << sh;
				store_strb_out = 8'h0f << addr_lo_in;
			end
			lsia_pkg::LSIA_STORE_DOUBLEWORD: begin
				store_data_out = target_in;
				store_strb_out = 8'hff;
			end
			lsia_pkg::LSIA_STORE_WORD_LEFT: begin
				store_data_out = ({32'h0, target_in[31:0]}
					>> (6'd24 - shw)) << {addr_lo_in[2], 5'h00};
				store_strb_out = (8'h0f >> (3'd3 - {1'b0, addr_lo_in[1:0]}))
					<< {addr_lo_in[2], 2'b00};
			end
			lsia_pkg::LSIA_STORE_WORD_RIGHT: begin
				store_data_out = {32'h0, target_in[31:0]} << sh;
				store_strb_out = ((8'h0f << addr_lo_in[1:0]) & 8'h0f)
					<< {addr_lo_in[2], 2'b00};
			end
			lsia_pkg::LSIA_STORE_DOUBLEWORD_LEFT: begin
				store_data_out = target_in >> (6'd56 - sh);
				store_strb_out = 8'hff >> (3'd7 - addr_lo_in);
			end
			lsia_pkg::LSIA_STORE_DOUBLEWORD_RIGHT: begin
				store_data_out = target_in << sh;
				store_strb_out = 8'hff << addr_lo_in;
			end
			default: store_data_out = 64'h0;
		endcase
	end

	always_comb begin
		case (op_in)
			lsia_pkg::LSIA_LOAD_HALFWORD_SIGNED,
			lsia_pkg::LSIA_LOAD_HALFWORD_ZERO_EXT,
			lsia_pkg::LSIA_STORE_HALFWORD:
				misaligned_out = addr_lo_in[0];
			lsia_pkg::LSIA_LOAD_WORD_SIGNED,
			lsia_pkg::LSIA_LOAD_WORD_ZERO_EXT,
			lsia_pkg::LSIA_STORE_WORD:
				misaligned_out = |addr_lo_in[1:0];
			lsia_pkg::LSIA_LOAD_DOUBLEWORD,
			lsia_pkg::LSIA_STORE_DOUBLEWORD:
				misaligned_out = |addr_lo_in;
			default: misaligned_out = 1'b0;
		endcase
	end
endmodule : lsia_align

// ===== design/lsia_core.sv
// Load/store and immediate ALU execution datapath, top level
`timescale 1ns/1ps
`include "lsia_map.svh"
module lsia_core (
	input  wire logic               clk_sys_in,
	input  wire logic               rst_n_in,
	input  wire logic               issue_valid_in,
	input  wire lsia_pkg::lsia_op_e issue_op_in,
	input  wire logic [63:0]        source_register_field_in,
	input  wire logic [63:0]        target_register_field_in,
	input  wire logic [15:0]        imm_in,
	input  wire logic               mode_64_in,
	input  wire logic               mem_rvalid_in,
	input  wire logic [63:0]        mem_rdata_in,
	output logic                    busy_out,
	output logic                    mem_req_out,
	output logic                    mem_we_out,
	output logic [63:0]             mem_addr_out,
	output logic [63:0]             mem_wdata_out,
	output logic [7:0]              mem_strb_out,
	output logic                    wb_valid_out,
	output logic [63:0]             wb_data_out,
	output logic                    overflow_exc_out,
	output logic                    addr_exc_out
);
	lsia_pkg::lsia_state_e state_reg, state_next;
	lsia_pkg::lsia_op_e    op_reg;
	logic [63:0] tgt_reg;
	logic [63:0] addr_reg;
	logic        busy_reg, mem_req_reg, mem_we_reg;
	logic [63:0] mem_addr_reg, mem_wdata_reg;
	logic [7:0]  mem_strb_reg;
	logic        wb_valid_reg, ovf_reg, aerr_reg;
	logic [63:0] wb_data_reg;
	logic [63:0] simm, zimm, vaddr, sum64, alu_res;
	logic [32:0] sum32;
	logic        is_load, is_store, is_alu, ovf_now;
	logic [63:0] ld_data, st_data;
	logic [7:0]  st_strb;
	logic        misal;
	logic        in_mem;

	assign simm  = {{48{imm_in[15]}}, imm_in};
	assign zimm  = {48'h0, imm_in};
	assign vaddr = source_register_field_in + simm;
	assign sum64 = source_register_field_in + simm;
	assign sum32 = {source_register_field_in[31],
		source_register_field_in[31:0]} + {simm[31], simm[31:0]};
	assign is_load  = issue_op_in inside {
		[lsia_pkg::LSIA_LOAD_BYTE_SIGNED:lsia_pkg::LSIA_LOAD_DOUBLEWORD_RIGHT]};
	assign is_store = issue_op_in inside {
		[lsia_pkg::LSIA_STORE_BYTE:lsia_pkg::LSIA_STORE_DOUBLEWORD_RIGHT]};
	assign is_alu = !is_load && !is_store
		&& issue_op_in != lsia_pkg::LSIA_NONE;

	// Immediate ALU result and overflow
	always_comb begin
		alu_res = 64'h0;
		ovf_now = 1'b0;
		case (issue_op_in)
			lsia_pkg::LSIA_ADD_IMMEDIATE_TRAPPING: begin
				alu_res = {{32{sum32[31]}}, sum32[31:0]};
				ovf_now = sum32[32] ^ sum32[31];
			end
			lsia_pkg::LSIA_DWORD_ADD_IMMEDIATE_TRAPPING: begin
				alu_res = sum64;
				ovf_now = (source_register_field_in[63] == simm[63])
					&& (sum64[63] != simm[63]);
			end
			lsia_pkg::LSIA_DWORD_ADD_IMMEDIATE_WRAPPING: alu_res = sum64;
			lsia_pkg::LSIA_SET_LESS_THAN_IMM_SIGNED:
				alu_res = {63'h0, $signed(source_register_field_in)
					< $signed(simm)};
			lsia_pkg::LSIA_SET_LESS_THAN_IMM_UNSIGNED:
				alu_res = {63'h0, source_register_field_in < simm};
			lsia_pkg::LSIA_AND_IMMEDIATE:
				alu_res = source_register_field_in & zimm;
			lsia_pkg::LSIA_OR_IMMEDIATE:
				alu_res = source_register_field_in | zimm;
			lsia_pkg::LSIA_EXCLUSIVE_OR_IMMEDIATE:
				alu_res = source_register_field_in ^ zimm;
			// upper immediate, sign-extended in 64-bit mode
			lsia_pkg::LSIA_LOAD_UPPER_IMMEDIATE:
				alu_res = mode_64_in ? {{32{imm_in[15]}}, imm_in, 16'h0}
					: {32'h0, imm_in, 16'h0};
			// register form: both operands from registers
			lsia_pkg::LSIA_ADD_REGISTER:
				alu_res = source_register_field_in + target_register_field_in;
			default: alu_res = 64'h0;
		endcase
	end

	// Load in flight uses captured context, not the live issue port
	assign in_mem = (state_reg == lsia_pkg::LSIA_ST_MEM);

	// low address bits pick low-order byte lane
	lsia_align u_align (
		.op_in          (in_mem ? op_reg : issue_op_in),
		.addr_lo_in     (in_mem ? addr_reg[2:0] : vaddr[2:0]),
		.mem_rdata_in   (mem_rdata_in),
		.target_in      (in_mem ? tgt_reg : target_register_field_in),
		.load_data_out  (ld_data),
		.store_data_out (st_data),
		.store_strb_out (st_strb),
		.misaligned_out (misal)
	);

	// Sequencer next state
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			lsia_pkg::LSIA_ST_IDLE:
				if (issue_valid_in && (is_load || is_store) && !misal)
					state_next = is_load ? lsia_pkg::LSIA_ST_MEM
						: lsia_pkg::LSIA_ST_DONE;
			lsia_pkg::LSIA_ST_MEM:
				if (mem_rvalid_in)
					state_next = lsia_pkg::LSIA_ST_DONE;
			lsia_pkg::LSIA_ST_DONE: state_next = lsia_pkg::LSIA_ST_IDLE;
			default: state_next = lsia_pkg::LSIA_ST_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in)
			state_reg <= lsia_pkg::LSIA_ST_IDLE;
		else
			state_reg <= state_next;
	end

	// Captured operation context for loads
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			op_reg   <= lsia_pkg::LSIA_NONE;
			tgt_reg  <= `LSIA_RESET_DATA;
			addr_reg <= `LSIA_RESET_DATA;
		end else if (state_reg == lsia_pkg::LSIA_ST_IDLE && issue_valid_in) begin
			op_reg   <= issue_op_in;
			tgt_reg  <= target_register_field_in;
			addr_reg <= vaddr;
		end
	end

	// Memory request outputs
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			mem_req_reg   <= 1'b0;
			mem_we_reg    <= 1'b0;
			mem_addr_reg  <= `LSIA_RESET_DATA;
			mem_wdata_reg <= `LSIA_RESET_DATA;
			mem_strb_reg  <= `LSIA_RESET_STRB;
		end else begin
			mem_req_reg <= 1'b0;
			mem_we_reg  <= 1'b0;
			if (state_reg == lsia_pkg::LSIA_ST_IDLE && issue_valid_in
				&& (is_load || is_store) && !misal) begin
				mem_req_reg   <= 1'b1;
				mem_we_reg    <= is_store;
				mem_addr_reg  <= {vaddr[63:3], 3'b000};
				mem_wdata_reg <= is_store ? st_data : 64'h0;
				mem_strb_reg  <= is_store ? st_strb : 8'hff;
			end
		end
	end

	// Writeback and exception outputs
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			wb_valid_reg <= 1'b0;
			wb_data_reg  <= `LSIA_RESET_DATA;
			ovf_reg      <= 1'b0;
			aerr_reg     <= 1'b0;
		end else begin
			wb_valid_reg <= 1'b0;
			ovf_reg      <= 1'b0;
			aerr_reg     <= 1'b0;
			if (state_reg == lsia_pkg::LSIA_ST_IDLE && issue_valid_in) begin
				if (is_alu) begin
					wb_valid_reg <= !ovf_now;
					wb_data_reg  <= alu_res;
					ovf_reg      <= ovf_now;
				end else if (misal) begin
					aerr_reg <= 1'b1;
				end
			end else if (state_reg == lsia_pkg::LSIA_ST_MEM && mem_rvalid_in) begin
				wb_valid_reg <= 1'b1;
				wb_data_reg  <= ld_data;
			end
		end
	end

	// Busy from a load or store issue until the sequencer is back in idle
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in)
			busy_reg <= 1'b0;
		else
			busy_reg <= (state_next != lsia_pkg::LSIA_ST_IDLE);
	end

	assign busy_out         = busy_reg;
	assign mem_req_out      = mem_req_reg;
	assign mem_we_out       = mem_we_reg;
	assign mem_addr_out     = mem_addr_reg;
	assign mem_wdata_out    = mem_wdata_reg;
	assign mem_strb_out     = mem_strb_reg;
	assign wb_valid_out     = wb_valid_reg;
	assign wb_data_out      = wb_data_reg;
	assign overflow_exc_out = ovf_reg;
	assign addr_exc_out     = aerr_reg;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	// Shared clock and reset for the checks
	default clocking cb_sys @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_n_in);
	a_add_trap: assert property (
		ovf_reg |-> !wb_valid_reg)
		else $error("overflow with writeback");
	a_wrap_notrap: assert property (
		(state_reg == lsia_pkg::LSIA_ST_IDLE && issue_valid_in
		&& issue_op_in == lsia_pkg::LSIA_DWORD_ADD_IMMEDIATE_WRAPPING)
		|=> wb_valid_reg && !ovf_reg && wb_data_reg == $past(sum64))
		else $error("wrapping add trapped or wrong");
	a_misal_noreq: assert property (
		aerr_reg |-> !mem_req_reg)
		else $error("access issued on address error");
	a_addr_form: assert property (
		mem_req_reg |-> mem_addr_reg[63:3] == $past(vaddr[63:3]))
		else $error("bad address");
	a_sb_strb: assert property (
		(mem_req_reg && mem_we_reg && $past(issue_op_in)
		== lsia_pkg::LSIA_STORE_BYTE) |-> $countones(mem_strb_reg) == 1)
		else $error("byte store strobe");
	a_sd_strb: assert property (
		(mem_req_reg && $past(issue_op_in) == lsia_pkg::LSIA_STORE_DOUBLEWORD)
		|-> mem_strb_reg == 8'hff)
		else $error("doubleword strobe");
	a_slt_bit: assert property (
		(state_reg == lsia_pkg::LSIA_ST_IDLE && issue_valid_in
		&& issue_op_in == lsia_pkg::LSIA_SET_LESS_THAN_IMM_SIGNED)
		|=> wb_data_reg[63:1] == 63'h0)
		else $error("compare result not 0 or 1");
	a_load_wb: assert property (
		(state_reg == lsia_pkg::LSIA_ST_MEM && mem_rvalid_in) |=> wb_valid_reg)
		else $error("load did not write back");
	c_load: cover property (@(posedge clk_sys_in) wb_valid_reg && !mem_we_reg);
	c_store: cover property (@(posedge clk_sys_in) mem_req_reg && mem_we_reg);
	c_ovf: cover property (@(posedge clk_sys_in) ovf_reg);
	c_aerr: cover property (@(posedge clk_sys_in) aerr_reg);
endmodule : lsia_core

// ===== sim/lsia_cache_model.sv
// Data cache model answering the datapath memory requests
`timescale 1ns/1ps
module lsia_cache_model (
	input  wire logic        clk_sys_in,
	input  wire logic        mem_req_in,
	input  wire logic        mem_we_in,
	input  wire logic [63:0] mem_addr_in,
	input  wire logic [63:0] mem_wdata_in,
	input  wire logic [7:0]  mem_strb_in,
	input  wire logic [3:0]  delay_in,
	output logic             mem_rvalid_out,
	output logic [63:0]      mem_rdata_out
);
	// ------------------------------------------------------------------
	// Storage and read pipeline
	// ------------------------------------------------------------------
	logic [63:0] mem_reg [8];
	logic [2:0]  slot_reg;
	logic [3:0]  cnt_reg;
	logic        pend_reg;

	// Empty store and idle answer lines
	initial begin
		for (int i = 0; i < 8; i++) begin
			mem_reg[i] = 64'h0;
		end
		mem_rvalid_out = 1'b0;
		mem_rdata_out = 64'h0;
		pend_reg = 1'b0;
		cnt_reg = 4'h0;
		slot_reg = 3'h0;
	end

	// Byte lane writes and delayed read answer
	always @(posedge clk_sys_in) begin
		mem_rvalid_out <= 1'b0;
		// Read data outside answers is not held
		mem_rdata_out <= ~mem_rdata_out;
		if (mem_req_in && mem_we_in) begin
			for (int b = 0; b < 8; b++) begin
				if (mem_strb_in[b]) begin
					mem_reg[mem_addr_in[5:3]][8*b +: 8] <= mem_wdata_in[8*b +: 8];
				end
			end
		end else if (mem_req_in) begin
			pend_reg <= 1'b1;
			cnt_reg <= delay_in;
			slot_reg <= mem_addr_in[5:3];
		end else if (pend_reg && cnt_reg != 4'h0) begin
			cnt_reg <= cnt_reg - 4'h1;
		end else if (pend_reg) begin
			pend_reg <= 1'b0;
			mem_rvalid_out <= 1'b1;
			mem_rdata_out <= mem_reg[slot_reg];
		end
	end
endmodule : lsia_cache_model

// ===== sim/lsia_core_bench.sv
// Self-checking bench for the load/store and immediate ALU datapath
`timescale 1ns/1ps
module lsia_core_bench;
	// ------------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------------
	localparam int          TIMEOUT_CYCLES = 3000;
	localparam logic [63:0] RV = 64'h0123_4567_89ab_cdef;
	localparam logic [63:0] MV = 64'hf1e2_d3c4_b5a6_9788;
	logic               clk_sys_in;
	logic               rst_n_in;
	logic               issue_valid;
	lsia_pkg::lsia_op_e op;
	logic [63:0]        src;
	logic [63:0]        tgt;
	logic [15:0]        imm;
	logic               mode_64;
	logic               rvalid;
	logic [63:0]        rdata;
	logic [3:0]         delay;
	logic               busy, req, we, wbv, ovf, aex;
	logic [63:0]        addr, wdata, wbd;
	logic [7:0]         strb;
	logic               got_req, got_wb, got_ovf, got_aex;
	logic [63:0]        c_addr, c_data, c_wb;
	logic [7:0]         c_strb;
	int                 miscompares, checks_done, cycles;

	// ------------------------------------------------------------------
	// Design and cache model
	// ------------------------------------------------------------------
	lsia_core i_lsia_core (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
		.issue_valid_in(issue_valid), .issue_op_in(op),
		.source_register_field_in(src), .target_register_field_in(tgt),
		.imm_in(imm), .mode_64_in(mode_64), .mem_rvalid_in(rvalid),
		.mem_rdata_in(rdata), .busy_out(busy), .mem_req_out(req),
		.mem_we_out(we), .mem_addr_out(addr), .mem_wdata_out(wdata),
		.mem_strb_out(strb), .wb_valid_out(wbv), .wb_data_out(wbd),
		.overflow_exc_out(ovf), .addr_exc_out(aex));
	lsia_cache_model i_lsia_cache_model (.clk_sys_in(clk_sys_in),
		.mem_req_in(req), .mem_we_in(we), .mem_addr_in(addr),
		.mem_wdata_in(wdata), .mem_strb_in(strb), .delay_in(delay),
		.mem_rvalid_out(rvalid), .mem_rdata_out(rdata));

	// Clock at 25 MHz
	initial begin
		clk_sys_in = 1'b0;
		forever #20 clk_sys_in = ~clk_sys_in;
	end

	// Hang guard
	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles == TIMEOUT_CYCLES) begin
			miscompares++;
			$display("ERROR at %0t: cycles %h limit %h", $time, cycles,
				TIMEOUT_CYCLES);
			end_of_test();
		end
	end

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Issue one operation and collect its answer
	task automatic run(input lsia_pkg::lsia_op_e o, input logic [63:0] s,
		input logic [63:0] t, input logic [15:0] i, input logic m);
		{got_req, got_wb, got_ovf, got_aex} = 4'h0;
		@(posedge clk_sys_in);
		while (busy !== 1'b0) @(posedge clk_sys_in);
		issue_valid <= 1'b1;
		op <= o;
		src <= s;
		tgt <= t;
		imm <= i;
		mode_64 <= m;
		@(posedge clk_sys_in);
		issue_valid <= 1'b0;
		for (int n = 0; n < 20; n++) begin
			#1;
			if (req === 1'b1) begin
				got_req = 1'b1;
				{c_addr, c_data, c_strb} = {addr, wdata, strb};
			end
			if (wbv === 1'b1) begin
				got_wb = 1'b1;
				c_wb = wbd;
			end
			got_ovf = (ovf === 1'b1);
			got_aex = (aex === 1'b1);
			if (got_wb || got_ovf || got_aex || (got_req && we === 1'b1))
				break;
			@(posedge clk_sys_in);
		end
	endtask : run

	task automatic alu(input lsia_pkg::lsia_op_e o, input logic [63:0] s,
		input logic [15:0] i, input logic [63:0] exp, input logic trap);
		run(o, s, 64'h0, i, 1'b1);
		chk(64'(got_ovf), 64'(trap));
		chk(64'(got_wb), 64'(!trap));
		if (!trap) chk(c_wb, exp);
	endtask : alu

	task automatic st(input lsia_pkg::lsia_op_e o, input logic [2:0] lo,
		input logic [7:0] es, input logic [63:0] ed);
		logic [63:0] mask;
		for (int b = 0; b < 8; b++) mask[8*b +: 8] = {8{es[b]}};
		run(o, 64'h120 + 64'(lo), RV, 16'hffe8, 1'b1);
		chk(64'({got_req, we}), 64'h3);
		chk(c_addr, 64'h108);
		chk(64'(c_strb), 64'(es));
		chk(c_data & mask, ed);
	endtask : st

	task automatic ld(input lsia_pkg::lsia_op_e o, input logic [2:0] lo,
		input logic [63:0] exp);
		run(o, 64'h18 + 64'(lo), RV, 16'hffe8, 1'b1);
		chk(c_addr, 64'h0);
		chk(64'(got_wb), 64'h1);
		chk(c_wb, exp);
	endtask : ld

	task automatic bad(input lsia_pkg::lsia_op_e o, input logic [2:0] lo);
		run(o, 64'h18 + 64'(lo), RV, 16'hffe8, 1'b1);
		chk(64'({got_aex, got_req}), 64'h2);
	endtask : bad

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_alu();
		alu(lsia_pkg::LSIA_ADD_IMMEDIATE_TRAPPING, 64'h7fff_fff0, 16'h0005,
			64'h7fff_fff5, 1'b0);
		alu(lsia_pkg::LSIA_ADD_IMMEDIATE_TRAPPING, 64'h7fff_ffff, 16'h0001,
			64'h0, 1'b1);
		alu(lsia_pkg::LSIA_DWORD_ADD_IMMEDIATE_TRAPPING, {1'b0, {63{1'b1}}},
			16'h0001, 64'h0, 1'b1);
		alu(lsia_pkg::LSIA_DWORD_ADD_IMMEDIATE_TRAPPING, 64'h1_0000_0000,
			16'hffff, 64'hffff_ffff, 1'b0);
		alu(lsia_pkg::LSIA_DWORD_ADD_IMMEDIATE_WRAPPING, {1'b0, {63{1'b1}}},
			16'h0001, {1'b1, 63'h0}, 1'b0);
		alu(lsia_pkg::LSIA_SET_LESS_THAN_IMM_SIGNED, -64'sd2, 16'hffff,
			64'h1, 1'b0);
		alu(lsia_pkg::LSIA_SET_LESS_THAN_IMM_SIGNED, 64'h1, 16'h8000,
			64'h0, 1'b0);
		alu(lsia_pkg::LSIA_SET_LESS_THAN_IMM_UNSIGNED, {1'b1, 63'h0},
			16'hffff, 64'h1, 1'b0);
		alu(lsia_pkg::LSIA_SET_LESS_THAN_IMM_UNSIGNED, {1'b1, 63'h0},
			16'h0001, 64'h0, 1'b0);
		alu(lsia_pkg::LSIA_AND_IMMEDIATE, {64{1'b1}}, 16'h8001, 64'h8001,
			1'b0);
		alu(lsia_pkg::LSIA_OR_IMMEDIATE, RV, 16'h8000, RV | 64'h8000,
			1'b0);
		alu(lsia_pkg::LSIA_EXCLUSIVE_OR_IMMEDIATE, RV, 16'hffff,
			RV ^ 64'hffff, 1'b0);
		alu(lsia_pkg::LSIA_LOAD_UPPER_IMMEDIATE, RV, 16'h8001,
			64'hffff_ffff_8001_0000, 1'b0);
		run(lsia_pkg::LSIA_LOAD_UPPER_IMMEDIATE, RV, 64'h0, 16'h8001, 1'b0);
		chk(c_wb, 64'h0000_0000_8001_0000);
		run(lsia_pkg::LSIA_ADD_REGISTER, 64'h5, 64'h3, 16'h0, 1'b1);
		chk(c_wb, 64'h8);
		$display("Test alu done");
	endtask : t_alu

	task automatic t_store();
		st(lsia_pkg::LSIA_STORE_DOUBLEWORD, 3'h0, 8'hff, RV);
		st(lsia_pkg::LSIA_STORE_BYTE, 3'h3, 8'h08,
			{32'h0, RV[7:0], 24'h0});
		st(lsia_pkg::LSIA_STORE_HALFWORD, 3'h6, 8'hc0,
			{RV[15:0], 48'h0});
		st(lsia_pkg::LSIA_STORE_DOUBLEWORD_LEFT, 3'h2, 8'h07,
			{40'h0, RV[63:40]});
		st(lsia_pkg::LSIA_STORE_DOUBLEWORD_RIGHT, 3'h5, 8'he0,
			{RV[23:0], 40'h0});
		st(lsia_pkg::LSIA_STORE_WORD_LEFT, 3'h5, 8'h30,
			{16'h0, RV[31:16], 32'h0});
		st(lsia_pkg::LSIA_STORE_WORD_RIGHT, 3'h1, 8'h0e,
			{32'h0, RV[23:0], 8'h0});
		st(lsia_pkg::LSIA_STORE_WORD_RIGHT, 3'h6, 8'hc0,
			{RV[15:0], 48'h0});
		st(lsia_pkg::LSIA_STORE_WORD, 3'h4, 8'hf0,
			{RV[31:0], 32'h0});
		bad(lsia_pkg::LSIA_STORE_DOUBLEWORD, 3'h4);
		$display("Test store done");
	endtask : t_store

	task automatic t_load();
		run(lsia_pkg::LSIA_STORE_DOUBLEWORD, 64'h18, MV, 16'hffe8, 1'b1);
		ld(lsia_pkg::LSIA_LOAD_BYTE_SIGNED, 3'h7,
			{{56{MV[63]}}, MV[63:56]});
		ld(lsia_pkg::LSIA_LOAD_BYTE_ZERO_EXT, 3'h7,
			{56'h0, MV[63:56]});
		ld(lsia_pkg::LSIA_LOAD_HALFWORD_SIGNED, 3'h2,
			{{48{MV[31]}}, MV[31:16]});
		ld(lsia_pkg::LSIA_LOAD_WORD_ZERO_EXT, 3'h4,
			{32'h0, MV[63:32]});
		ld(lsia_pkg::LSIA_LOAD_HALFWORD_ZERO_EXT, 3'h6,
			{48'h0, MV[63:48]});
		ld(lsia_pkg::LSIA_LOAD_WORD_SIGNED, 3'h4,
			{{32{MV[63]}}, MV[63:32]});
		ld(lsia_pkg::LSIA_LOAD_DOUBLEWORD, 3'h0, MV);
		@(posedge clk_sys_in);
		delay <= 4'h6;
		ld(lsia_pkg::LSIA_LOAD_WORD_LEFT, 3'h5,
			{{32{MV[47]}}, MV[47:32], RV[15:0]});
		ld(lsia_pkg::LSIA_LOAD_WORD_RIGHT, 3'h1,
			{{32{RV[31]}}, RV[31:24], MV[31:8]});
		ld(lsia_pkg::LSIA_LOAD_DOUBLEWORD_LEFT, 3'h3,
			{MV[31:0], RV[31:0]});
		ld(lsia_pkg::LSIA_LOAD_DOUBLEWORD_RIGHT, 3'h3,
			{RV[63:40], MV[63:24]});
		bad(lsia_pkg::LSIA_LOAD_HALFWORD_SIGNED, 3'h1);
		bad(lsia_pkg::LSIA_LOAD_WORD_ZERO_EXT, 3'h2);
		$display("Test load done");
	endtask : t_load

	task automatic end_of_test();
		$display("Checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_of_test

	// Reset then run every scenario
	initial begin
		{rst_n_in, issue_valid, mode_64, src, tgt, imm, delay} = '0;
		op = lsia_pkg::LSIA_NONE;
		repeat (10) @(posedge clk_sys_in);
		chk(wbd | wdata | addr, 64'h0);
		rst_n_in <= 1'b1;
		t_alu();
		t_store();
		t_load();
		end_of_test();
	end
endmodule : lsia_core_bench
